/* logic/can_flags_map.svh */
`ifndef CAN_FLAGS_MAP_SVH
`define CAN_FLAGS_MAP_SVH

// register byte addresses
`define ABORT_ACK_OFS 8'h00
`define RX_COMPLETE_OFS 8'h04
`define REMOTE_REQUEST_OFS 8'h08
`define TX_WAIT_OFS 8'h0c
`define TX_CANCEL_OFS 8'h10
`define IRQ_STATUS_OFS 8'h14
`define IRQ_CLEAR_OFS 8'h18
`define IRQ_ENABLE_OFS 8'h1c
`define RX_SUMMARY_OFS 8'h20

// reset values and field layout
`define FLAGS_RST 16'h0000
`define MAILBOX0_BIT 8
`define NO_MAILBOX0_MASK 16'hfeff
`define TX_WAIT_RSVD_READ 16'h0100
`define EVT_RST 3'h0
`define EVT_ABORT_BIT 0
`define EVT_RX_BIT 1
`define EVT_REMOTE_BIT 2

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* logic/can_flags_pkg.sv */
`default_nettype none
package can_flags_pkg;
  typedef logic [15:0] flags_t;
  typedef enum logic [3:0] {
    SEL_ABORT = 4'h0,
    SEL_RX = 4'h1,
    SEL_REMOTE = 4'h2,
    SEL_TX_WAIT = 4'h3,
    SEL_TX_CANCEL = 4'h4,
    SEL_STATUS = 4'h5,
    SEL_CLEAR = 4'h6,
    SEL_ENABLE = 4'h7,
    SEL_SUMMARY = 4'h8,
    SEL_NONE = 4'hf
  } reg_sel_t;
endpackage
`default_nettype wire

/* logic/can_mailbox_status_flags.sv */
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`default_nettype none
`include "can_flags_map.svh"
module can_mailbox_status_flags
  import can_flags_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [15:0] abort_done_in,
  input wire logic [15:0] tx_done_in,
  input wire logic [15:0] rx_done_in,
  input wire logic [15:0] rx_remote_in,
  output logic [15:0] transmit_wait_out,
  output logic [15:0] transmit_cancel_out,
  output logic rx_message_irq_out,
  output logic irq_out,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);

  function automatic reg_sel_t decode(input logic [7:0] a);
    case (a)
      `ABORT_ACK_OFS: decode = SEL_ABORT;
      `RX_COMPLETE_OFS: decode = SEL_RX;
      `REMOTE_REQUEST_OFS: decode = SEL_REMOTE;
      `TX_WAIT_OFS: decode = SEL_TX_WAIT;
      `TX_CANCEL_OFS: decode = SEL_TX_CANCEL;
      `IRQ_STATUS_OFS: decode = SEL_STATUS;
      `IRQ_CLEAR_OFS: decode = SEL_CLEAR;
      `IRQ_ENABLE_OFS: decode = SEL_ENABLE;
      `RX_SUMMARY_OFS: decode = SEL_SUMMARY;
      default: decode = SEL_NONE;
    endcase
  endfunction

  flags_t abort_ack_flags;
  flags_t rx_complete_flags;
  flags_t remote_request_flags;
  flags_t transmit_wait_bits;
  flags_t transmit_cancel_bits;
  flags_t abort_evt;
  flags_t rx_evt;
  flags_t remote_evt;
  flags_t tx_evt;
  flags_t next_abort;
  flags_t next_rx;
  flags_t next_remote;
  flags_t next_wait;
  flags_t next_cancel;
  flags_t wmask;
  logic [2:0] status;
  logic [2:0] enable;
  logic [2:0] next_status;
  logic [2:0] next_enable;
  logic [2:0] evt;
  logic aw_held;
  logic w_held;
  logic [7:0] waddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic do_write;
  reg_sel_t wr_sel;

  // engine vectors are indexed by mailbox; registers put mailbox 0 at bit 8, 1-7 from bit 15 down, 8-15 from bit 0 up
  for (genvar m = 0; m < 16; m++)
  begin : g_map
    localparam int P = (m == 0) ? `MAILBOX0_BIT : ((m < 8) ? (16 - m) : (m - 8));
    assign abort_evt[P] = (m == 0) ? 1'b0 : abort_done_in[m];
    assign tx_evt[P] = (m == 0) ? 1'b0 : tx_done_in[m];
    assign rx_evt[P] = rx_done_in[m];
    assign remote_evt[P] = rx_done_in[m] & rx_remote_in[m];
  end

  // write channel: address and data taken in either order, one write in flight
  assign do_write = aw_held & w_held & ~s_axi_bvalid_out;
  assign wr_sel = decode(waddr);
  assign wmask = {{8{wstrb[1]}}, {8{wstrb[0]}}} & wdata[15:0];

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      s_axi_awready_out <= 1'b1;
      aw_held <= 1'b0;
      waddr <= 8'h00;
    end
    else if (s_axi_awvalid_in && s_axi_awready_out)
    begin
      s_axi_awready_out <= 1'b0;
      aw_held <= 1'b1;
      waddr <= s_axi_awaddr_in;
    end
    else if (do_write)
      aw_held <= 1'b0;
    else if (s_axi_bvalid_out && s_axi_bready_in)
      s_axi_awready_out <= 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      s_axi_wready_out <= 1'b1;
      w_held <= 1'b0;
      wdata <= 32'h0000_0000;
      wstrb <= 4'h0;
    end
    else if (s_axi_wvalid_in && s_axi_wready_out)
    begin
      s_axi_wready_out <= 1'b0;
      w_held <= 1'b1;
      wdata <= s_axi_wdata_in;
      wstrb <= s_axi_wstrb_in;
    end
    else if (do_write)
      w_held <= 1'b0;
    else if (s_axi_bvalid_out && s_axi_bready_in)
      s_axi_wready_out <= 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end
    else if (s_axi_bready_in)
      s_axi_bvalid_out <= 1'b0;
  end

  // set is or-ed in after the clear so an event never gets lost
  always_comb
  begin
    next_abort = abort_ack_flags;
    next_rx = rx_complete_flags;
    next_remote = remote_request_flags;
    next_wait = transmit_wait_bits;
    next_enable = enable;
    next_status = status;
    if (do_write)
    begin
      unique case (wr_sel)
        SEL_ABORT: next_abort = abort_ack_flags & ~wmask;
        SEL_RX: next_rx = rx_complete_flags & ~wmask;
        SEL_REMOTE: next_remote = remote_request_flags & ~wmask;
        SEL_TX_WAIT: next_wait = transmit_wait_bits | wmask;
        SEL_CLEAR: next_status = status & ~wdata[2:0];
        SEL_ENABLE: next_enable = wdata[2:0];
        SEL_TX_CANCEL, SEL_STATUS, SEL_SUMMARY, SEL_NONE: ;
      endcase
    end
    next_abort = (next_abort | abort_evt) & `NO_MAILBOX0_MASK;
    next_rx = next_rx | rx_evt;
    next_remote = next_remote | remote_evt;
    next_wait = next_wait & ~(tx_evt | abort_evt) & `NO_MAILBOX0_MASK;
    next_status = next_status | evt;
  end

  // a cancel request only lives while its wait bit does
  always_comb
  begin
    next_cancel = transmit_cancel_bits;
    if (do_write && wr_sel == SEL_TX_CANCEL)
      next_cancel = transmit_cancel_bits | wmask;
    next_cancel = next_cancel & next_wait;
  end

  assign evt = {|remote_evt, |rx_evt, |abort_evt};

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      abort_ack_flags <= `FLAGS_RST;
      rx_complete_flags <= `FLAGS_RST;
      remote_request_flags <= `FLAGS_RST;
    end
    else
    begin
      abort_ack_flags <= next_abort;
      rx_complete_flags <= next_rx;
      remote_request_flags <= next_remote;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      transmit_wait_bits <= `FLAGS_RST;
      transmit_cancel_bits <= `FLAGS_RST;
    end
    else
    begin
      transmit_wait_bits <= next_wait;
      transmit_cancel_bits <= next_cancel;
    end
  end

  assign transmit_wait_out = transmit_wait_bits;
  assign transmit_cancel_out = transmit_cancel_bits;

  // summary flag falls only with the last receive-complete bit
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      rx_message_irq_out <= 1'b0;
    else
      rx_message_irq_out <= (|rx_evt) | (rx_message_irq_out & (|next_rx));
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      status <= `EVT_RST;
      enable <= `EVT_RST;
      irq_out <= 1'b0;
    end
    else
    begin
      status <= next_status;
      enable <= next_enable;
      irq_out <= |(next_status & next_enable);
    end
  end

  // read channel: data sampled at the edge that takes the address
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= `RESP_OKAY;
    end
    else if (s_axi_arvalid_in && s_axi_arready_out)
    begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out <= `RESP_OKAY;
      s_axi_rdata_out <= 32'h0000_0000;
      unique case (decode(s_axi_araddr_in))
        SEL_ABORT: s_axi_rdata_out[15:0] <= abort_ack_flags;
        SEL_RX: s_axi_rdata_out[15:0] <= rx_complete_flags;
        SEL_REMOTE: s_axi_rdata_out[15:0] <= remote_request_flags;
        SEL_TX_WAIT: s_axi_rdata_out[15:0] <= transmit_wait_bits | `TX_WAIT_RSVD_READ;
        SEL_TX_CANCEL: s_axi_rdata_out[15:0] <= transmit_cancel_bits;
        SEL_STATUS: s_axi_rdata_out[2:0] <= status;
        SEL_CLEAR: ;
        SEL_ENABLE: s_axi_rdata_out[2:0] <= enable;
        SEL_SUMMARY: s_axi_rdata_out[0] <= rx_message_irq_out;
        SEL_NONE: s_axi_rresp_out <= `RESP_SLVERR;
      endcase
    end
    else if (s_axi_rvalid_out && s_axi_rready_in)
    begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  a_abort_set: assert property (abort_done_in[1] |=> abort_ack_flags[15])
    else $error("abort flag of mailbox 1 not set");
  a_abort_map: assert property (abort_done_in[8] |=> abort_ack_flags[0])
    else $error("abort flag of mailbox 8 not at bit 0");
  a_abort_rsvd: assert property (abort_done_in[0] |=> !abort_ack_flags[8])
    else $error("abort bit 8 set");
  a_rx_mailbox0: assert property (rx_done_in[0] |=> rx_complete_flags[8])
    else $error("mailbox 0 receive flag not at bit 8");
  a_rx_map: assert property (rx_done_in[5] |=> rx_complete_flags[11])
    else $error("mailbox 5 receive flag not at bit 11");
  a_remote_pair: assert property (rx_done_in[0] && rx_remote_in[0]
    |=> rx_complete_flags[8] && remote_request_flags[8])
    else $error("remote frame flags not set together");
  a_remote_only: assert property ($rose(remote_request_flags[8])
    |-> $past(rx_done_in[0] && rx_remote_in[0]))
    else $error("remote flag rose without remote frame");
  a_zero_keeps: assert property (do_write && wr_sel == SEL_RX && !wmask[0]
    && rx_complete_flags[0] |=> rx_complete_flags[0])
    else $error("written 0 cleared a flag");
  a_set_wins: assert property (do_write && wr_sel == SEL_RX && wmask[0]
    && rx_done_in[8] |=> rx_complete_flags[0])
    else $error("clear beat a coincident set");
  a_cancel_clears: assert property (abort_done_in[3]
    |=> !transmit_wait_out[13] && !transmit_cancel_out[13])
    else $error("cancel did not clear wait and cancel bits");
  a_summary_level: assert property (rx_message_irq_out == (|rx_complete_flags))
    else $error("summary flag disagrees with receive flags");

  c_remote_rx: cover property (rx_done_in[0] && rx_remote_in[0]);
  c_set_clear: cover property (do_write && wr_sel == SEL_RX && |(wmask & rx_evt));
  c_irq: cover property ($rose(irq_out));

endmodule // can_mailbox_status_flags
`default_nettype wire

/* tb/can_engine_model.sv */
`default_nettype none
module can_engine_model
(
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [1:0] kind_in,
  input wire logic [3:0] mb_in,
  output logic [15:0] abort_done_out,
  output logic [15:0] tx_done_out,
  output logic [15:0] rx_done_out,
  output logic [15:0] rx_remote_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] hit;
  assign hit = 16'h0001 << mb_in;
  // kinds: 0 abort, 1 data frame, 2 remote frame, 3 sent; one-cycle pulses
  // outputs settle to zero at the first edge, long before reset is released
  always @(posedge clk_in)
  begin
    abort_done_out <= (go_in && kind_in == 2'h0) ? hit : 16'h0000;
    tx_done_out <= (go_in && kind_in == 2'h3) ? hit : 16'h0000;
    rx_done_out <= (go_in && (kind_in == 2'h1 || kind_in == 2'h2)) ? hit : 16'h0000;
    rx_remote_out <= (go_in && kind_in == 2'h2) ? hit : 16'h0000;
  end
endmodule // can_engine_model
`default_nettype wire

/* tb/tb.sv */
`default_nettype none
`include "can_flags_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic go = 1'b0;
  logic [1:0] kind = 2'h0;
  logic [3:0] mb = 4'h0;
  logic [15:0] abort_done, tx_done, rx_done, rx_remote, wait_bits, cancel_bits;
  logic rx_irq, irq, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [1:0] bresp, rresp;
  int fails = 0;
  int samples_checked = 0;

  can_engine_model can_engine_model_inst (.clk_in(clk_in), .go_in(go), .kind_in(kind),
    .mb_in(mb), .abort_done_out(abort_done), .tx_done_out(tx_done),
    .rx_done_out(rx_done), .rx_remote_out(rx_remote));
  can_mailbox_status_flags can_mailbox_status_flags_inst (.clk_in(clk_in),
    .srst_in(srst_in), .abort_done_in(abort_done), .tx_done_in(tx_done),
    .rx_done_in(rx_done), .rx_remote_in(rx_remote), .transmit_wait_out(wait_bits),
    .transmit_cancel_out(cancel_bits), .rx_message_irq_out(rx_irq), .irq_out(irq),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));

  initial
  begin
    forever #25 clk_in = ~clk_in;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_in);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    r = bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk_in);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask

  // engine event: model register at the edge that drops go, then two edges: flag register plus one spare
  task automatic ev(input logic [1:0] k, input logic [3:0] m);
    @(posedge clk_in);
    go <= 1'b1;
    kind <= k;
    mb <= m;
    @(posedge clk_in);
    go <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
  endtask

  // mailbox 0 at bit 8, 1-7 from bit 15 down, 8-15 from bit 0 up
  function automatic logic [31:0] lay(input int m);
    if (m == 0) return 32'h0000_0100;
    return (m < 8) ? (32'h1 << (16 - m)) : (32'h1 << (m - 8));
  endfunction

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 3; i++)
    begin
      rd(8'(4 * i), d, r);
      chk(d, 32'h0000_0000, "flags after reset");
    end
    rd(8'h40, d, r);
    chk({d[29:0], r}, {30'h0, `RESP_SLVERR}, "unmapped read");
    wr(8'h44, 32'h0000_ffff, r);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR}, "unmapped write");
  endtask

  task automatic t_abort();
    logic [31:0] d;
    logic [1:0] r;
    int mbs[4] = '{1, 7, 8, 15};
    foreach (mbs[i])
    begin
      ev(2'h0, 4'(mbs[i]));
      rd(`ABORT_ACK_OFS, d, r);
      chk(d, lay(mbs[i]), "abort flag set");
      wr(`ABORT_ACK_OFS, 32'h0000_0000, r);
      rd(`ABORT_ACK_OFS, d, r);
      chk(d, lay(mbs[i]), "abort flag after zero write");
      wr(`ABORT_ACK_OFS, lay(mbs[i]), r);
      rd(`ABORT_ACK_OFS, d, r);
      chk(d, 32'h0000_0000, "abort flag cleared");
    end
    ev(2'h0, 4'h0);
    rd(`ABORT_ACK_OFS, d, r);
    chk(d, 32'h0000_0000, "abort bit 8");
  endtask

  task automatic t_rx();
    logic [31:0] d;
    logic [1:0] r;
    ev(2'h1, 4'h5);
    ev(2'h2, 4'h0);
    rd(`RX_COMPLETE_OFS, d, r);
    chk(d, lay(5) | lay(0), "receive flags");
    rd(`REMOTE_REQUEST_OFS, d, r);
    chk(d, lay(0), "remote flags");
    wr(`RX_COMPLETE_OFS, lay(5), r);
    chk({31'h0, rx_irq}, 32'h1, "summary with one flag left");
    wr(`RX_COMPLETE_OFS, lay(0), r);
    chk({31'h0, rx_irq}, 32'h0, "summary after all cleared");
    rd(`REMOTE_REQUEST_OFS, d, r);
    chk(d, lay(0), "remote flag kept");
    wr(`REMOTE_REQUEST_OFS, lay(0), r);
    rd(`REMOTE_REQUEST_OFS, d, r);
    chk(d, 32'h0000_0000, "remote flag cleared");
  endtask

  task automatic t_irq();
    logic [31:0] d;
    logic [1:0] r;
    ev(2'h1, 4'h8);
    chk({31'h0, irq}, 32'h0, "masked interrupt");
    wr(`IRQ_ENABLE_OFS, 32'h0000_0002, r);
    chk({31'h0, irq}, 32'h1, "enabled interrupt");
    wr(`IRQ_CLEAR_OFS, 32'h0000_0002, r);
    chk({31'h0, irq}, 32'h0, "cleared interrupt");
    wr(`RX_COMPLETE_OFS, 32'h0000_0000, r);
    rd(`RX_COMPLETE_OFS, d, r);
    chk(d, lay(8), "receive flag after zero write");
    wr(`RX_COMPLETE_OFS, lay(8), r);
    // both start on one edge, so the event meets the clear at the write edge
    fork
      ev(2'h1, 4'h8);
      wr(`RX_COMPLETE_OFS, lay(8), r);
    join
    rd(`RX_COMPLETE_OFS, d, r);
    chk(d, lay(8), "set against coincident clear");
    wr(`RX_COMPLETE_OFS, lay(8), r);
    rd(`RX_COMPLETE_OFS, d, r);
    chk(d, 32'h0000_0000, "receive flag cleared");
  endtask

  task automatic t_cancel();
    logic [31:0] d;
    logic [1:0] r;
    wr(`TX_WAIT_OFS, lay(3) | lay(10) | 32'h0000_0100, r);
    wr(`TX_CANCEL_OFS, lay(3), r);
    rd(`TX_CANCEL_OFS, d, r);
    chk(d, lay(3), "cancel bit set");
    chk({16'h0000, cancel_bits}, lay(3), "cancel pins set");
    ev(2'h0, 4'h3);
    ev(2'h3, 4'ha);
    rd(`TX_WAIT_OFS, d, r);
    chk(d, 32'h0000_0100, "wait bits cleared");
    chk({16'h0000, wait_bits}, 32'h0000_0000, "wait pins cleared");
    rd(`TX_CANCEL_OFS, d, r);
    chk(d, 32'h0000_0000, "cancel bit cleared");
    chk({16'h0000, cancel_bits}, 32'h0000_0000, "cancel pins cleared");
    rd(`ABORT_ACK_OFS, d, r);
    chk(d, lay(3), "abort after cancel");
  endtask

  // all scenarios need a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk_in);
    fails++;
    summarize();
  end

  initial
  begin
    repeat (16) @(posedge clk_in);
    srst_in <= 1'b0;
    t_reset();
    t_abort();
    t_rx();
    t_irq();
    t_cancel();
    summarize();
  end
endmodule // tb
`default_nettype wire
